// ---- design/fdr_pkg.sv ----
// Constants and types shared by the floppy drive control register block.
// Assumes a 100 MHz system clock and a 10-bit host address already qualified.
package fdr_pkg;

	// Operating modes chosen by static configuration.
	typedef enum logic [1:0] {
		FDR_MODE_AT,
		FDR_MODE_ALT,
		FDR_MODE_ENH
	} fdr_mode_type;

	// Host register addresses, primary base.
	localparam logic [9:0] ADDR_STATUS_B = 10'h3f1;
	localparam logic [9:0] ADDR_DOR = 10'h3f2;
	localparam logic [9:0] ADDR_TDR = 10'h3f3;
	localparam logic [9:0] ADDR_DIR = 10'h3f7;

	// Reset values.
	localparam logic [7:0] DOR_RESET = 8'h00;
	localparam logic [1:0] TDR_RESET = 2'h0;

	// Drive output control field positions.
	localparam int DOR_SEL_LSB = 0;
	localparam int DOR_SEL_MSB = 1;
	localparam int DOR_RST_BIT = 2;
	localparam int DOR_DMA_BIT = 3;
	localparam int DOR_MOT0_BIT = 4;
	localparam int DOR_MOT1_BIT = 5;
	localparam int DOR_MOT2_BIT = 6;
	localparam int DOR_MOT3_BIT = 7;

	// Status register B field positions in the alternate layout.
	localparam int SRB_DS2_BIT = 0;
	localparam int SRB_DS3_BIT = 1;
	localparam int SRB_WG_BIT = 2;
	localparam int SRB_RD_BIT = 3;
	localparam int SRB_WD_BIT = 4;
	localparam int SRB_DS0_BIT = 5;
	localparam int SRB_DS1_BIT = 6;
	localparam int SRB_SECOND_DRIVE_PRESENT_BIT = 7;

	// On a tape register read only the two select bits drive the data bus; output control and alternate status register B reads drive all eight.
	localparam logic [7:0] TDR_OE_MASK = 8'h03;
	localparam logic [7:0] FULL_OE_MASK = 8'hff;

	// Software reset minimum width, rounded up to whole clock cycles.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOFT_RST_NS = 100;
	localparam int SOFT_CNT_W = 4;
	localparam logic [SOFT_CNT_W-1:0] SOFT_RST_CYC =
		SOFT_CNT_W'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ---- design/fdr_edge_flag.sv ----
// Sticky flag set by one chosen edge of a level and cleared by a strobe.
// Assumes the level is synchronous to ref_clk.
module fdr_edge_flag #(
	parameter bit FALL_EDGE = 1'b0
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Watched level and clear strobe.
	input wire logic level,
	input wire logic clear,
	// Latched flag.
	output logic flag_ff
);

	// Previous sample of the level, for edge detection.
	logic prev_ff;
	// Edge of the chosen direction seen in this cycle.
	logic edge_seen;

	// A fall is seen when the level drops, a rise when it climbs.
	assign edge_seen = FALL_EDGE ? (prev_ff & ~level) : (~prev_ff & level);

	// Sample the level every cycle.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= level;
		end
	end

	// The set wins over the clear so that an edge during a clearing read is kept.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			flag_ff <= 1'b0;
		end else if (edge_seen) begin
			flag_ff <= 1'b1;
		end else if (clear) begin
			flag_ff <= 1'b0;
		end
	end

endmodule

// ---- design/fdr_drive_ctrl.sv ----
// Floppy drive control registers: drive output control, tape assignment,
// alternate status register B and DMA and interrupt pin gating.
// Assumes host strobes and all pins are synchronous to ref_clk.

module fdr_drive_ctrl (
	// Clock and hardware reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Static configuration.
	input wire fdr_pkg::fdr_mode_type mode,
	input wire logic drive_swap,
	// Host register access.
	input wire logic [9:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic [7:0] host_rdata_oe,
	// Drive interface status levels.
	input wire logic write_gate_out,
	input wire logic read_data_active,
	input wire logic write_data_active,
	input wire logic second_drive_present,
	// Drive select and motor outputs.
	output logic drive_select_zero_n,
	output logic drive_select_one_n,
	output logic drive_select_two_n,
	output logic drive_select_three_n,
	output logic motor_on_zero_n,
	output logic motor_on_one_n,
	output logic motor_on_two_n,
	output logic motor_on_three_n,
	// Controller reset and tape handling.
	output logic soft_reset_n,
	output logic [1:0] tape_drive_num,
	output logic tape_drive_active,
	// DMA and interrupt from and to the controller core.
	input wire logic core_dma_request,
	input wire logic core_irq,
	output logic core_dma_ack_n,
	output logic core_terminal_count,
	// DMA and interrupt pins.
	input wire logic dma_ack_n,
	input wire logic terminal_count,
	output logic dma_request,
	output logic dma_request_oe,
	output logic floppy_irq_out,
	output logic floppy_irq_oe
);

	// Drive output control register.
	logic [7:0] dor_ff;
	// Tape drive assignment, two bits only.
	logic [1:0] tdr_ff;
	// Soft reset stretch counter and registered reset output.
	logic [fdr_pkg::SOFT_CNT_W-1:0] soft_cnt_ff;
	logic soft_reset_n_ff;
	// Registered drive outputs and their next values.
	logic [3:0] ds_n_ff;
	logic [3:0] nxt_ds_n;
	logic [3:0] mot_n_ff;
	logic [3:0] nxt_mot_n;
	// Read data path.
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [7:0] rdata_oe_ff;
	logic [7:0] nxt_rdata_oe;
	// Latched status flags.
	logic wg_flag;
	logic rd_flag;
	logic wd_flag;
	// Decoded strobes.
	logic dor_wr;
	logic tdr_wr;
	logic dir_rd;
	logic pins_on;

	// Two-drive decode of selects and motors for drives zero and one.
	// Returns {ds1_n, ds0_n, mtr1_n, mtr0_n}.
	function automatic logic [3:0] two_drive(input logic [7:0] drive_output_control, input logic swap);
		logic sel0;
		logic sel1;
		sel0 = (drive_output_control[1:0] == 2'h0) && drive_output_control[fdr_pkg::DOR_MOT0_BIT];
		sel1 = (drive_output_control[1:0] == 2'h1) && drive_output_control[fdr_pkg::DOR_MOT1_BIT];
		if (swap) begin
			two_drive = {~sel0, ~sel1, ~drive_output_control[fdr_pkg::DOR_MOT0_BIT],
				~drive_output_control[fdr_pkg::DOR_MOT1_BIT]};
		end else begin
			two_drive = {~sel1, ~sel0, ~drive_output_control[fdr_pkg::DOR_MOT1_BIT],
				~drive_output_control[fdr_pkg::DOR_MOT0_BIT]};
		end
	endfunction

	// Address decode; the mode and swap inputs are treated as static.
	assign dor_wr = host_wr && (host_addr == fdr_pkg::ADDR_DOR);
	assign tdr_wr = host_wr && (host_addr == fdr_pkg::ADDR_TDR);
	assign dir_rd = host_rd && (host_addr == fdr_pkg::ADDR_DIR);

	// Drive output control: writable at any time, untouched by soft reset.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			dor_ff <= fdr_pkg::DOR_RESET;
		end else if (dor_wr) begin
			dor_ff <= host_wdata;
		end
	end

	// Tape assignment keeps only its two select bits, also through soft reset.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tdr_ff <= fdr_pkg::TDR_RESET;
		end else if (tdr_wr) begin
			tdr_ff <= host_wdata[1:0];
		end
	end

	// Stretch the soft reset so back-to-back writes of 0 then 1 still give
	// the controller its minimum reset width.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			soft_cnt_ff <= fdr_pkg::SOFT_RST_CYC;
		end else if (dor_wr && !host_wdata[fdr_pkg::DOR_RST_BIT]) begin
			soft_cnt_ff <= fdr_pkg::SOFT_RST_CYC;
		end else if (soft_cnt_ff != '0) begin
			soft_cnt_ff <= soft_cnt_ff - 1'b1;
		end
	end

	// Reset output is low while the bit is 0 or the stretch is running.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			soft_reset_n_ff <= 1'b0;
		end else begin
			soft_reset_n_ff <= dor_ff[fdr_pkg::DOR_RST_BIT] && (soft_cnt_ff == '0);
		end
	end

	// Next drive select and motor levels, ordered {3, 2, 1, 0}.
	always_comb begin
		logic [3:0] two;
		two = two_drive(dor_ff, drive_swap);
		// Drives two and three follow the plain binary select.
		nxt_ds_n[3] = ~(dor_ff[fdr_pkg::DOR_SEL_MSB:fdr_pkg::DOR_SEL_LSB] == 2'h3);
		nxt_ds_n[2] = ~(dor_ff[fdr_pkg::DOR_SEL_MSB:fdr_pkg::DOR_SEL_LSB] == 2'h2);
		nxt_ds_n[1:0] = two[3:2];
		nxt_mot_n[3] = ~dor_ff[fdr_pkg::DOR_MOT3_BIT];
		nxt_mot_n[2] = ~dor_ff[fdr_pkg::DOR_MOT2_BIT];
		nxt_mot_n[1:0] = two[1:0];
	end

	// Register the drive pins so they never glitch while the decode settles.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ds_n_ff <= 4'hf;
			mot_n_ff <= 4'hf;
		end else begin
			ds_n_ff <= nxt_ds_n;
			mot_n_ff <= nxt_mot_n;
		end
	end

	assign drive_select_zero_n = ds_n_ff[0];
	assign drive_select_one_n = ds_n_ff[1];
	assign drive_select_two_n = ds_n_ff[2];
	assign drive_select_three_n = ds_n_ff[3];
	assign motor_on_zero_n = mot_n_ff[0];
	assign motor_on_one_n = mot_n_ff[1];
	assign motor_on_two_n = mot_n_ff[2];
	assign motor_on_three_n = mot_n_ff[3];
	assign soft_reset_n = soft_reset_n_ff;

	// Drive zero can never be a tape, so a zero assignment means none.
	assign tape_drive_num = tdr_ff;
	assign tape_drive_active = (tdr_ff != 2'h0) &&
		(dor_ff[fdr_pkg::DOR_SEL_MSB:fdr_pkg::DOR_SEL_LSB] == tdr_ff);

	// Enhanced mode leaves the pins live even while the enable bit is clear.
	assign pins_on = (mode == fdr_pkg::FDR_MODE_ENH) || dor_ff[fdr_pkg::DOR_DMA_BIT];
	// Disabled inputs read as idle; disabled outputs float.
	assign core_dma_ack_n = pins_on ? dma_ack_n : 1'b1;
	assign core_terminal_count = pins_on ? terminal_count : 1'b0;
	assign dma_request = core_dma_request;
	assign dma_request_oe = pins_on;
	assign floppy_irq_out = core_irq;
	assign floppy_irq_oe = pins_on;

	// Latched write gate rise, read data and write data falls.
	fdr_edge_flag #(.FALL_EDGE(1'b0)) u_wg_flag (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.level(write_gate_out),
		.clear(dir_rd),
		.flag_ff(wg_flag)
	);
	fdr_edge_flag #(.FALL_EDGE(1'b1)) u_rd_flag (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.level(read_data_active),
		.clear(dir_rd),
		.flag_ff(rd_flag)
	);
	// Write data is watched whether or not the write gate is active.
	fdr_edge_flag #(.FALL_EDGE(1'b1)) u_wd_flag (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.level(write_data_active),
		.clear(dir_rd),
		.flag_ff(wd_flag)
	);

	// Read multiplexer; unmapped or unsupported reads leave the bus floating.
	always_comb begin
		nxt_rdata = 8'h00;
		nxt_rdata_oe = 8'h00;
		if (host_rd) begin
			case (host_addr)
				fdr_pkg::ADDR_STATUS_B: begin
					// Only the alternate layout is offered here.
					if (mode == fdr_pkg::FDR_MODE_ALT) begin
						nxt_rdata[fdr_pkg::SRB_DS2_BIT] = ds_n_ff[2];
						nxt_rdata[fdr_pkg::SRB_DS3_BIT] = ds_n_ff[3];
						nxt_rdata[fdr_pkg::SRB_WG_BIT] = wg_flag;
						nxt_rdata[fdr_pkg::SRB_RD_BIT] = rd_flag;
						nxt_rdata[fdr_pkg::SRB_WD_BIT] = wd_flag;
						nxt_rdata[fdr_pkg::SRB_DS0_BIT] = ds_n_ff[0];
						nxt_rdata[fdr_pkg::SRB_DS1_BIT] = ds_n_ff[1];
						nxt_rdata[fdr_pkg::SRB_SECOND_DRIVE_PRESENT_BIT] = ~second_drive_present;
						nxt_rdata_oe = fdr_pkg::FULL_OE_MASK;
					end
				end
				fdr_pkg::ADDR_DOR: begin
					nxt_rdata = dor_ff;
					nxt_rdata_oe = fdr_pkg::FULL_OE_MASK;
				end
				fdr_pkg::ADDR_TDR: begin
					// Upper bits float on a read.
					nxt_rdata = {6'h00, tdr_ff};
					nxt_rdata_oe = fdr_pkg::TDR_OE_MASK;
				end
				default: begin
					nxt_rdata = 8'h00;
					nxt_rdata_oe = 8'h00;
				end
			endcase
		end
	end

	// Read data and its enables stand for one cycle after the strobe.
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata_ff <= 8'h00;
			rdata_oe_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
			rdata_oe_ff <= nxt_rdata_oe;
		end
	end

	assign host_rdata = rdata_ff;
	assign host_rdata_oe = rdata_oe_ff;

	// All checks run on the one system clock. Hardware reset disables them, so the
	// pin gating that must hold during reset is checked from the bench instead.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_srb_drive_sel: assert property (
		host_rd && host_addr == fdr_pkg::ADDR_STATUS_B && mode == fdr_pkg::FDR_MODE_ALT
		|=> host_rdata[0] == $past(drive_select_two_n)
		&& host_rdata[6] == $past(drive_select_one_n)
		&& host_rdata[7] == !$past(second_drive_present))
		else $error("Status register B drive bits wrong.");
	a_write_gate_out_latch: assert property ($rose(write_gate_out) |=> wg_flag)
		else $error("Write gate edge not latched.");
	a_rdata_latch: assert property ($fell(read_data_active) |=> rd_flag)
		else $error("Read data edge not latched.");
	// The flag must hold after its edge unless an input register read clears it.
	a_wdata_latch: assert property (
		$fell(write_data_active) |=> wd_flag ##1 (wd_flag || $past(dir_rd)))
		else $error("Write data flag not held.");
	a_dir_clear: assert property (
		dir_rd && !$rose(write_gate_out) |=> !wg_flag)
		else $error("Input register read did not clear flag.");
	// Writes stay legal during a soft reset; only an unwritten register must hold.
	a_dor_reset: assert property (!soft_reset_n_ff && !dor_wr |=> $stable(dor_ff))
		else $error("Output register changed during soft reset.");
	// Ten cycles of the system clock make up the minimum reset width.
	a_soft_width: assert property (
		$fell(soft_reset_n) |-> !soft_reset_n[*8] ##1 !soft_reset_n ##1 !soft_reset_n)
		else $error("Soft reset shorter than minimum.");
	a_reset_hold: assert property (
		dor_wr && !host_wdata[2] |=> ##1 !soft_reset_n)
		else $error("Soft reset not asserted.");
	a_pin_gate: assert property (
		mode != fdr_pkg::FDR_MODE_ENH && !dor_ff[3]
		|-> !dma_request_oe && !floppy_irq_oe && core_dma_ack_n && !core_terminal_count)
		else $error("DMA pins not gated off.");
	a_enh_pins: assert property (mode == fdr_pkg::FDR_MODE_ENH |-> dma_request_oe)
		else $error("Enhanced mode pins disabled.");
	a_norm_decode: assert property (
		!drive_swap && dor_ff[1:0] == 2'h0 && dor_ff[4]
		|=> !drive_select_zero_n && drive_select_one_n && !motor_on_zero_n)
		else $error("Normal decode wrong.");
	a_swap_decode: assert property (
		drive_swap && dor_ff[1:0] == 2'h1 && dor_ff[5]
		|=> !drive_select_zero_n && drive_select_one_n && motor_on_one_n == !$past(dor_ff[4]))
		else $error("Swapped decode wrong.");
	a_tape_keep: assert property (!soft_reset_n && !tdr_wr |=> $stable(tdr_ff))
		else $error("Tape register changed in soft reset.");
	a_tape_read: assert property (
		host_rd && host_addr == fdr_pkg::ADDR_TDR |=> host_rdata_oe == 8'h03)
		else $error("Tape read drives upper bits.");
	a_one_select: assert property (
		$onehot0(~{drive_select_three_n, drive_select_two_n, drive_select_one_n,
			drive_select_zero_n}))
		else $error("More than one drive selected.");
	a_motor_out: assert property (
		1'b1 |=> {motor_on_three_n, motor_on_two_n} ==
			~$past(dor_ff[fdr_pkg::DOR_MOT3_BIT:fdr_pkg::DOR_MOT2_BIT]))
		else $error("Motor outputs two or three wrong.");
	a_srb_float: assert property (
		host_rd && host_addr == fdr_pkg::ADDR_STATUS_B && mode != fdr_pkg::FDR_MODE_ALT
		|=> host_rdata_oe == 8'h00)
		else $error("Status register B driven outside alternate mode.");

	// Main scenarios; the bench reaches all but c_soft_toggle, as its writes are never back to back.

	c_soft_toggle: cover property (dor_wr && !host_wdata[2] ##1 dor_wr && host_wdata[2]);
	c_srb_read: cover property (wg_flag && host_rd && host_addr == fdr_pkg::ADDR_STATUS_B);
	c_tape_use: cover property (tape_drive_active);
	c_enh_gate: cover property (mode == fdr_pkg::FDR_MODE_ENH && !dor_ff[fdr_pkg::DOR_DMA_BIT]);
	c_flag_clear: cover property (dir_rd && wd_flag);

endmodule

// ---- sim/fdr_drive_model.sv ----
// Behavioural model of the floppy drives on the far side of the drive pins.
// Assumes the bench asks for read data pulses and states whether a second drive is fitted.
module fdr_drive_model (
	// Clock.
	input wire logic ref_clk,
	// Commands from the bench.
	input wire logic pulse_req,
	input wire logic installed,
	// Drive status pins.
	output logic read_data_active,
	output logic second_drive_present
);
	timeunit 1ns;
	timeprecision 1ps;

	// A flux pulse lasts one clock and the line idles low, as a drive does between transitions.
	always_ff @(posedge ref_clk) begin
		read_data_active <= pulse_req;
	end

	// The presence strap is a plain level from the drive cable.
	assign second_drive_present = installed;
endmodule

// ---- sim/fdr_drive_ctrl_test.sv ----
// Self-checking bench for the floppy drive control registers.
// Assumes the design package is compiled first; drives inputs on falling edges.
module fdr_drive_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;

	// Design stimulus and observed outputs.
	logic ref_clk, rstn, drive_swap, host_rd, host_wr, pulse_req, second_drive_present_in;
	fdr_pkg::fdr_mode_type mode;
	logic [9:0] host_addr;
	logic [7:0] host_wdata, host_rdata, host_rdata_oe, e;
	logic write_gate_out, read_data_active, write_data_active, second_drive_present;
	logic ds0_n, ds1_n, ds2_n, ds3_n, mt0_n, mt1_n, mt2_n, mt3_n;
	logic soft_reset_n, tape_drive_active;
	logic [1:0] tape_drive_num;
	logic core_dma_request, core_irq, core_dma_ack_n, core_terminal_count;
	logic dma_ack_n, terminal_count, dma_request, dma_request_oe, floppy_irq_out, floppy_irq_oe;
	int fail_count, num_checks, n;
	// Drive activation values plus one case with the motor bit clear and one with all four motor bits set.
	logic [7:0] dor_tab [6] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f, 8'h01, 8'hf0};

	fdr_drive_ctrl fdr_drive_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .mode(mode),
		.drive_swap(drive_swap), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
		.write_gate_out(write_gate_out), .read_data_active(read_data_active),
		.write_data_active(write_data_active), .second_drive_present(second_drive_present),
		.drive_select_zero_n(ds0_n), .drive_select_one_n(ds1_n), .drive_select_two_n(ds2_n),
		.drive_select_three_n(ds3_n), .motor_on_zero_n(mt0_n), .motor_on_one_n(mt1_n),
		.motor_on_two_n(mt2_n), .motor_on_three_n(mt3_n), .soft_reset_n(soft_reset_n),
		.tape_drive_num(tape_drive_num), .tape_drive_active(tape_drive_active),
		.core_dma_request(core_dma_request), .core_irq(core_irq),
		.core_dma_ack_n(core_dma_ack_n), .core_terminal_count(core_terminal_count),
		.dma_ack_n(dma_ack_n), .terminal_count(terminal_count), .dma_request(dma_request),
		.dma_request_oe(dma_request_oe), .floppy_irq_out(floppy_irq_out),
		.floppy_irq_oe(floppy_irq_oe));

	fdr_drive_model fdr_drive_model_inst (.ref_clk(ref_clk), .pulse_req(pulse_req),
		.installed(second_drive_present_in), .read_data_active(read_data_active),
		.second_drive_present(second_drive_present));

	// Free-running 100 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Counts a comparison and reports a difference at once.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and stops; shared by the main sequence and the watchdog.
	task automatic finish_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One write strobe, then one idle cycle so the drive pins have settled on return.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(negedge ref_clk);
		host_wr = 1'b0;
		@(negedge ref_clk);
	endtask

	// One read strobe; data and enables are looked at in the single cycle they stand.
	task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] oe);
		@(negedge ref_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge ref_clk);
		host_rd = 1'b0;
		chk(host_rdata_oe, oe);
		chk(host_rdata & oe, d);
	endtask

	// Expected motor and select pins, three down to zero, from the register and swap option.
	function automatic logic [7:0] pins_exp(input logic [7:0] drive_output_control, input logic swap);
		logic [3:0] ds;
		logic [3:0] mt;
		ds = 4'hf;
		mt = ~drive_output_control[7:4];
		case (drive_output_control[1:0])
			2'h0: ds[0] = ~drive_output_control[4];
			2'h1: ds[1] = ~drive_output_control[5];
			2'h2: ds[2] = 1'b0;
			default: ds[3] = 1'b0;
		endcase
		// Swapping exchanges both the selects and the motors of drives zero and one.
		if (swap) begin
			ds[1:0] = {ds[0], ds[1]};
			mt[1:0] = {mt[0], mt[1]};
		end
		return {mt, ds};
	endfunction

	// Cuts a hang short; the whole sequence needs well under this span.
	initial begin
		#100us;
		fail_count++;
		finish_test();
	end

	// Main sequence: one pass each for plain, alternate and enhanced swapped setups.
	initial begin
		{rstn, drive_swap, host_rd, host_wr, pulse_req, write_gate_out, write_data_active} = '0;
		{host_addr, host_wdata} = '0;
		mode = fdr_pkg::FDR_MODE_AT;
		{second_drive_present_in, core_dma_request, core_irq, terminal_count, dma_ack_n} = 5'h1e;
		fail_count = 0;
		num_checks = 0;
		for (int p = 0; p < 3; p++) begin
			mode = fdr_pkg::fdr_mode_type'(p);
			drive_swap = (p == 2);
			rstn = 1'b0;
			repeat (10) @(negedge ref_clk);
			rstn = 1'b1;
			chk({6'h0, dma_request_oe, floppy_irq_oe}, {6'h0, {2{p == 2}}});
			chk({7'h0, soft_reset_n}, 8'h00);
			rd(fdr_pkg::ADDR_DOR, 8'h00, 8'hff);
			for (int i = 0; i < 6; i++) begin
				wr(fdr_pkg::ADDR_DOR, dor_tab[i]);
				e = pins_exp(dor_tab[i], drive_swap);
				chk({mt3_n, mt2_n, mt1_n, mt0_n, ds3_n, ds2_n, ds1_n, ds0_n}, e);
			end
			// Tape assignment: only the two select bits are kept and driven back.
			wr(fdr_pkg::ADDR_TDR, 8'hff);
			rd(fdr_pkg::ADDR_TDR, 8'h03, 8'h03);
			wr(fdr_pkg::ADDR_DOR, 8'h8f);
			chk({5'h0, tape_drive_num, tape_drive_active}, 8'h07);
			wr(fdr_pkg::ADDR_TDR, 8'hfc);
			chk({5'h0, tape_drive_num, tape_drive_active}, 8'h00);
			wr(fdr_pkg::ADDR_TDR, 8'h02);
			// Soft reset by two consecutive writes must still last the minimum width.
			wr(fdr_pkg::ADDR_DOR, 8'h8b);
			chk({7'h0, soft_reset_n}, 8'h00);
			wr(fdr_pkg::ADDR_DOR, 8'h8f);
			repeat (5) @(negedge ref_clk);
			chk({7'h0, soft_reset_n}, 8'h00);
			n = 0;
			while (soft_reset_n !== 1'b1 && n < 20) begin
				@(negedge ref_clk);
				n++;
			end
			chk({7'h0, soft_reset_n}, 8'h01);
			rd(fdr_pkg::ADDR_DOR, 8'h8f, 8'hff);
			rd(fdr_pkg::ADDR_TDR, 8'h02, 8'h03);
			// DMA and interrupt pin gating with the enable bit low, then high.
			wr(fdr_pkg::ADDR_DOR, 8'h84);
			chk({dma_request_oe, floppy_irq_oe, ~core_dma_ack_n, core_terminal_count, 4'h0},
				{{4{p == 2}}, 4'h0});
			wr(fdr_pkg::ADDR_DOR, 8'h8c);
			chk({dma_request_oe, floppy_irq_oe, ~core_dma_ack_n, core_terminal_count,
				dma_request, floppy_irq_out, 2'h0}, 8'hfc);
			if (p == 1) begin
				// Select drive one and pull the presence strap so both show in status.
				wr(fdr_pkg::ADDR_DOR, 8'h2d);
				second_drive_present_in = 1'b0;
				// Write gate rises, write data and read data fall; all three must latch.
				@(negedge ref_clk);
				{write_gate_out, write_data_active, pulse_req} = 3'h7;
				@(negedge ref_clk);
				{write_gate_out, write_data_active, pulse_req} = 3'h0;
				repeat (3) @(negedge ref_clk);
				e = pins_exp(8'h2d, 1'b0);
				rd(fdr_pkg::ADDR_STATUS_B, {1'b1, e[1], e[0], 3'h7, e[3], e[2]}, 8'hff);
				rd(fdr_pkg::ADDR_DIR, 8'h00, 8'h00);
				second_drive_present_in = 1'b1;
				rd(fdr_pkg::ADDR_STATUS_B, {1'b0, e[1], e[0], 3'h0, e[3], e[2]}, 8'hff);
			end else begin
				rd(fdr_pkg::ADDR_STATUS_B, 8'h00, 8'h00);
			end
			rd(10'h3f0, 8'h00, 8'h00);
		end
		finish_test();
	end
endmodule
